// File: include/adc_readout_pkg.sv
// Shared constants for the converter result readout link
// Summary of operation
// - Format input high gives straight binary
// - First result after power-up is discarded
// - Parallel reads keep data; serial clocks shift
// - Offset binary equals two's complement MSB flipped
// - Bus driven only when read high, select low
// - Parallel-only host: source select high, clock low
// - Byte low: upper eight; high: low nibble
// - Busy rises only after output register loads
// - Host starts reads only with busy high; internal stream caught while converting
// - Serial data always driven, bus still decoded
// - Internal mode: twelve pulses, MSB first
// - Internal bit stable over both clock edges
// - After twelfth pulse: clock low, chain level
// - External clock shifts only when read enabled
// - Host serial clock slow, balanced duty
// - Keep read or clock low near load
// - Conversion always runs on own clock
// - External shift allowed during conversion
// - Convert commands ignored while busy low
// - Host releases select or read before busy
// - External clock: MSB after first rising, LSB after twelfth
// - Chain bits follow the result, one per pulse
package adc_readout_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RES_W = 12;
  // Conversion length and where the result is loaded
  localparam int CONV_NS = 15000;
  localparam int CONV_CYC = CONV_NS / CLK_PERIOD_NS;
  localparam int LOAD_LEAD_CYC = 2;
  // Least convert pulse, rounded up
  localparam int START_NS = 40;
  localparam int START_CYC = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Internal serial clock, period rounded down, split in quarters
  localparam int INT_CLK_KHZ = 900;
  localparam int INT_PERIOD_CYC = 1000000 / (INT_CLK_KHZ * CLK_PERIOD_NS);
  localparam int INT_QTR_CYC = INT_PERIOD_CYC / 4;
  // Host serial clock made by division
  localparam int EXT_PERIOD_NS = 160;
  localparam int EXT_HALF_CYC = EXT_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // Host wait for the bus to settle through both synchronisers
  localparam int PAR_SETTLE_CYC = 6;
  localparam logic [RES_W-1:0] OFFSET_FLIP = 12'h800;
  // Synchroniser reset values: selects idle high
  localparam logic [6:0] DEV_SYNC_RESET = 7'h64;
  localparam logic [10:0] HOST_SYNC_RESET = 11'h400;
  // Host register map
  localparam int AXI_AW = 5;
  localparam logic [AXI_AW-1:0] OFF_CTRL = 5'h00;
  localparam logic [AXI_AW-1:0] OFF_CMD = 5'h04;
  localparam logic [AXI_AW-1:0] OFF_STATUS = 5'h08;
  localparam logic [AXI_AW-1:0] OFF_PAR = 5'h0c;
  localparam logic [AXI_AW-1:0] OFF_SER = 5'h10;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_FMT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_BUSY_N_BIT = 0;
  localparam int ST_ENGINE_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam logic [1:0] CMD_CONVERT = 2'h1;
  localparam logic [1:0] CMD_PAR_READ = 2'h2;
  localparam logic [1:0] CMD_SER_READ = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : adc_readout_pkg

// File: include/adc_link_if.sv
// Pin-level link between converter readout port and host
`timescale 1ns/1ps
interface adc_link_if;
  logic cs_n; // Chip select, active low
  logic read_convert; // High reads, low converts
  logic byte_select; // Low upper byte, high lower
  logic format_select; // High straight binary
  logic clk_src_sel; // High host clock, low internal
  logic busy_n; // Low while converting
  logic serial_data_out; // Always driven by the converter
  logic [7:0] parallel_data_bus; // Converter bus value
  logic pbus_oe; // Converter drives the bus
  logic sclk_dev_o; // Converter clock drive
  logic sclk_dev_oe;
  logic sclk_host_o; // Host clock drive
  logic sclk_host_oe;
  logic serial_clock_pin; // Resolved wire, weak pull-down
  assign serial_clock_pin = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe & sclk_host_o);
  modport device (
    input cs_n, read_convert, byte_select, format_select, clk_src_sel, serial_clock_pin,
    output busy_n, serial_data_out, parallel_data_bus, pbus_oe, sclk_dev_o, sclk_dev_oe
  );
  modport host (
    output cs_n, read_convert, byte_select, format_select, clk_src_sel,
    output sclk_host_o, sclk_host_oe,
    input busy_n, serial_data_out, parallel_data_bus, pbus_oe, serial_clock_pin
  );
endinterface : adc_link_if

// File: hw/sync_2ff.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg; // Only q reads this flop

  // Two stages; reset to idle pin levels so no false command appears
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync_2ff

// File: hw/adc_readout_device.sv
// Converter end: conversion timing, output register, parallel and serial readout
`timescale 1ns/1ps
module adc_readout_device
  import adc_readout_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  adc_link_if.device link,
  input wire logic [RES_W-1:0] analog_code,
  input wire logic chain_in,
  output logic sample_strobe,
  output logic result_valid
);
  typedef enum logic {st_idle, st_convert} conv_state_t;

  logic [6:0] pins_raw; // Pin levels from the host side
  logic [6:0] pins_s; // Same, synchronised
  logic cs_n_s;
  logic rc_s;
  logic byte_s;
  logic fmt_s;
  logic ext_s;
  logic sclk_s;
  logic chain_s;

  conv_state_t state_reg;
  conv_state_t state_next;
  logic [9:0] conv_cnt_reg; // Cycles into the conversion
  logic [9:0] conv_cnt_next;
  logic start_cmd; // Convert command accepted
  logic load_pt; // Result moves into output register
  logic conv_end; // Last conversion cycle

  logic [RES_W-1:0] hold_reg; // Held sample, two's complement
  logic [RES_W-1:0] coded; // Sample in selected format
  logic [RES_W-1:0] out_reg; // Output shift register
  logic first_done_reg; // Power-up conversion seen
  logic valid_reg; // A usable result is present
  logic strobe_reg;
  logic tag_hold_reg; // Chain level at transmission start

  logic tx_active_reg; // Internal-clock transmission running
  logic [3:0] bit_cnt_reg; // Pulses already sent
  logic [5:0] phase_cnt_reg; // Position within one bit
  logic phase_last;
  logic int_shift;
  logic sclk_out_reg;

  logic sclk_prev_reg; // Last synchronised host clock level
  logic read_en; // Select low and read high
  logic ext_rise; // Host clock rising, read enabled
  logic shift; // Any shift this cycle
  logic shift_in; // Bit entering at the bottom

  logic serial_data_out_reg;
  logic [7:0] pdata_reg;
  logic pbus_oe_reg;
  logic sclk_oe_reg;
  logic busy_n_reg;

  // All control pins and the host clock pass two flops first
  assign pins_raw = {link.cs_n, link.read_convert, link.byte_select, link.format_select,
                     link.clk_src_sel, link.serial_clock_pin, chain_in};

  sync_2ff #(
    .WIDTH(7),
    .RESET_VAL(DEV_SYNC_RESET)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins_s)
  );

  assign cs_n_s = pins_s[6];
  assign rc_s = pins_s[5];
  assign byte_s = pins_s[4];
  assign fmt_s = pins_s[3];
  assign ext_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign chain_s = pins_s[0];

  // Level-triggered start, only from idle; commands during busy are dropped
  assign start_cmd = (state_reg == st_idle) && !cs_n_s && !rc_s;
  // Load a few cycles before the end so busy trails the new data
  assign load_pt = (state_reg == st_convert) &&
                   (conv_cnt_reg == 10'(CONV_CYC - 1 - LOAD_LEAD_CYC));
  assign conv_end = (state_reg == st_convert) && (conv_cnt_reg == 10'(CONV_CYC - 1));
  assign state_next = start_cmd ? st_convert : (conv_end ? st_idle : state_reg);
  assign conv_cnt_next = (state_reg == st_convert) ? conv_cnt_reg + 10'h001 : 10'h000;

  // Conversion timing runs on clk whatever the serial clock source
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= st_idle;
      conv_cnt_reg <= 10'h000;
    end
    else
    begin
      state_reg <= state_next;
      conv_cnt_reg <= conv_cnt_next;
    end
  end

  // Busy rises the edge after conversion end, two cycles after the load
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_n_reg <= 1'b1;
    else
      busy_n_reg <= (state_next == st_idle);
  end

  // Sample and chain level are caught as the conversion starts
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_reg <= 12'h000;
      tag_hold_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end
    else
    begin
      strobe_reg <= start_cmd;
      if (start_cmd)
      begin
        hold_reg <= analog_code;
        tag_hold_reg <= chain_s;
      end
    end
  end

  // Straight binary is the two's complement code with its MSB inverted
  assign coded = fmt_s ? (hold_reg ^ OFFSET_FLIP) : hold_reg;

  // Internal clock: data set at phase 0, high from one to three quarters
  assign phase_last = (phase_cnt_reg == 6'(4 * INT_QTR_CYC - 1));
  assign int_shift = tx_active_reg && (phase_cnt_reg == 6'h00);

  // Internal transmission: twelve pulses then one last shift to the chain level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_active_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      phase_cnt_reg <= 6'h00;
    end
    else if (start_cmd && !ext_s)
    begin
      tx_active_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      phase_cnt_reg <= 6'h00;
    end
    else if (tx_active_reg)
    begin
      phase_cnt_reg <= phase_last ? 6'h00 : phase_cnt_reg + 6'h01;
      if (phase_last)
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (int_shift && (bit_cnt_reg == 4'(RES_W)))
        tx_active_reg <= 1'b0;
    end
  end

  // Generated clock, held low once the twelfth pulse is out
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclk_out_reg <= 1'b0;
    else
      sclk_out_reg <= tx_active_reg && (bit_cnt_reg < 4'(RES_W)) &&
                      (phase_cnt_reg >= 6'(INT_QTR_CYC)) &&
                      (phase_cnt_reg < 6'(3 * INT_QTR_CYC));
  end

  // Host clock edges are found only after synchronisation
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclk_prev_reg <= 1'b0;
    else
      sclk_prev_reg <= sclk_s;
  end

  assign read_en = !cs_n_s && rc_s;
  // Shift on each host rising edge while read is enabled, also while converting
  assign ext_rise = ext_s && read_en && sclk_s && !sclk_prev_reg;
  assign shift = ext_rise || int_shift;
  // Chain input is clocked in behind the result
  assign shift_in = ext_s ? chain_s : tag_hold_reg;

  // Output register; load has priority so both can never land together.
  // A host edge in the load cycle is lost, which the host must avoid.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      out_reg <= 12'h000;
    else if (load_pt && first_done_reg)
      out_reg <= coded;
    else if (shift)
      out_reg <= {out_reg[RES_W-2:0], shift_in};
  end

  // Serial pin shows the bit leaving the register: MSB after the first shift
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      serial_data_out_reg <= 1'b0;
    else if (shift)
      serial_data_out_reg <= out_reg[RES_W-1];
  end

  // Power-up conversion is never loaded; valid after the next one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_done_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else if (load_pt)
    begin
      first_done_reg <= 1'b1;
      valid_reg <= valid_reg | first_done_reg;
    end
  end

  // Bus byte mux; reading leaves the register untouched
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pdata_reg <= 8'h00;
    else if (byte_s)
      pdata_reg <= {out_reg[3:0], 4'h0};
    else
      pdata_reg <= out_reg[RES_W-1:4];
  end

  // Pin enables from synchronised selects
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pbus_oe_reg <= 1'b0;
      sclk_oe_reg <= 1'b0;
    end
    else
    begin
      pbus_oe_reg <= read_en;
      sclk_oe_reg <= !ext_s;
    end
  end

  assign link.busy_n = busy_n_reg;
  assign link.serial_data_out = serial_data_out_reg;
  assign link.parallel_data_bus = pdata_reg;
  assign link.pbus_oe = pbus_oe_reg;
  assign link.sclk_dev_o = sclk_out_reg;
  assign link.sclk_dev_oe = sclk_oe_reg;
  assign sample_strobe = strobe_reg;
  assign result_valid = valid_reg;
endmodule : adc_readout_device

// File: hw/adc_readout_host.sv
// Host end: AXI4-Lite command registers driving the readout link
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_readout_host
  import adc_readout_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  adc_link_if.host link
);
  typedef enum {h_idle, h_start, h_wait, h_par_hi, h_par_lo, h_ser} host_state_t;

  logic aw_full_reg;
  logic w_full_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] ctrl_reg; // Clock source and format
  logic done_reg; // Sticky command-complete flag
  logic finish; // Engine completes this cycle
  host_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [3:0] pcnt_reg; // Serial pulses issued
  logic [RES_W-1:0] par_reg;
  logic [RES_W-1:0] ser_reg;
  logic cs_n_reg;
  logic rc_reg;
  logic byte_reg;
  logic sclk_reg;
  logic sclk_prev_reg;
  logic [10:0] in_s; // Synchronised link inputs
  logic busy_n_s;
  logic serial_data_out_s;
  logic sclk_s;
  logic do_wr;
  logic wr_lo; // Low byte lane written
  logic wr_ok;
  logic [1:0] cmd;
  logic [31:0] rd_mux;
  logic rd_ok;

  sync_2ff #(
    .WIDTH(11),
    .RESET_VAL(HOST_SYNC_RESET)
  ) u_in_sync (
    .clk(clk),
    .rst(rst),
    .d({link.busy_n, link.serial_data_out, link.serial_clock_pin, link.parallel_data_bus}),
    .q(in_s)
  );
  assign busy_n_s = in_s[10];
  assign serial_data_out_s = in_s[9];
  assign sclk_s = in_s[8];

  // Address and data are taken in either order; response waits for both
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_lo = do_wr && wstrb_reg[0];
  assign wr_ok = (awaddr_reg == OFF_CTRL) || (awaddr_reg == OFF_CMD) ||
                 (awaddr_reg == OFF_STATUS);
  assign cmd = (wr_lo && (awaddr_reg == OFF_CMD)) ? wdata_reg[1:0] : 2'h0;
  assign rd_ok = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_STATUS) ||
                 (s_axi_araddr == OFF_PAR) || (s_axi_araddr == OFF_SER);
  assign rd_mux = (s_axi_araddr == OFF_CTRL) ? {30'h0, ctrl_reg} :
                  (s_axi_araddr == OFF_STATUS) ?
                  {29'h0, done_reg, state_reg != h_idle, busy_n_s} :
                  (s_axi_araddr == OFF_PAR) ? {20'h0, par_reg} :
                  (s_axi_araddr == OFF_SER) ? {20'h0, ser_reg} : 32'h0;

  // Write channel holding and response
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_full_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (do_wr)
        w_full_reg <= 1'b0;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Control bits; done flag where a completion beats a clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET;
      done_reg <= 1'b0;
    end
    else
    begin
      if (wr_lo && (awaddr_reg == OFF_CTRL) && (state_reg == h_idle))
        ctrl_reg <= wdata_reg[1:0];
      done_reg <= finish || (done_reg &&
                  !(wr_lo && (awaddr_reg == OFF_STATUS) && wdata_reg[ST_DONE_BIT]));
    end
  end

  assign finish = ((state_reg == h_wait) && busy_n_s) ||
                  ((state_reg == h_par_lo) && (cnt_reg == 4'(PAR_SETTLE_CYC))) ||
                  ((state_reg == h_ser) && (pcnt_reg == 4'(RES_W)));

  // Command engine; reads only start while the converter is idle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= h_idle;
      cnt_reg <= 4'h0;
      pcnt_reg <= 4'h0;
      cs_n_reg <= 1'b1;
      rc_reg <= 1'b1;
      byte_reg <= 1'b0;
      sclk_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      par_reg <= 12'h000;
      ser_reg <= 12'h000;
    end
    else
    begin
      cnt_reg <= cnt_reg + 4'h1;
      sclk_prev_reg <= sclk_s;
      case (state_reg)
        h_idle:
        begin
          cnt_reg <= 4'h0;
          pcnt_reg <= 4'h0;
          byte_reg <= 1'b0;
          if (cmd == CMD_CONVERT)
          begin
            cs_n_reg <= 1'b0;
            rc_reg <= 1'b0;
            state_reg <= h_start;
          end
          else if ((cmd == CMD_PAR_READ) && busy_n_s)
          begin
            cs_n_reg <= 1'b0;
            state_reg <= h_par_hi;
          end
          else if ((cmd == CMD_SER_READ) && busy_n_s && ctrl_reg[CTRL_EXT_BIT])
          begin
            cs_n_reg <= 1'b0;
            state_reg <= h_ser;
          end
        end
        h_start:
          // Hold the convert pulse until the converter answers busy
          if ((cnt_reg >= 4'(START_CYC - 1)) && !busy_n_s)
          begin
            cs_n_reg <= 1'b1;
            rc_reg <= 1'b1;
            state_reg <= h_wait;
          end
        h_wait:
        begin
          // Internal mode: capture on generated rising edges
          if (sclk_s && !sclk_prev_reg && !ctrl_reg[CTRL_EXT_BIT])
            ser_reg <= {ser_reg[RES_W-2:0], serial_data_out_s};
          if (busy_n_s)
            state_reg <= h_idle;
        end
        h_par_hi:
          if (cnt_reg == 4'(PAR_SETTLE_CYC))
          begin
            par_reg[RES_W-1:4] <= in_s[7:0];
            byte_reg <= 1'b1;
            cnt_reg <= 4'h0;
            state_reg <= h_par_lo;
          end
        h_par_lo:
          if (cnt_reg == 4'(PAR_SETTLE_CYC))
          begin
            par_reg[3:0] <= in_s[7:4];
            cs_n_reg <= 1'b1;
            state_reg <= h_idle;
          end
        h_ser:
        begin
          // Four high then four low; the first low half already carries the MSB
          sclk_reg <= (cnt_reg < 4'(EXT_HALF_CYC));
          if (cnt_reg == 4'(2 * EXT_HALF_CYC - 1))
          begin
            cnt_reg <= 4'h0;
            ser_reg <= {ser_reg[RES_W-2:0], serial_data_out_s};
            pcnt_reg <= pcnt_reg + 4'h1;
          end
          if (pcnt_reg == 4'(RES_W))
          begin
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            state_reg <= h_idle;
          end
        end
        default:
          state_reg <= h_idle;
      endcase
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.read_convert = rc_reg;
  assign link.byte_select = byte_reg;
  assign link.format_select = ctrl_reg[CTRL_FMT_BIT];
  assign link.clk_src_sel = ctrl_reg[CTRL_EXT_BIT];
  assign link.sclk_host_o = sclk_reg;
  assign link.sclk_host_oe = ctrl_reg[CTRL_EXT_BIT];
endmodule : adc_readout_host

// File: sim/adc_link_sva.sv
// Checker of pin-level timing between the converter and host ends
`timescale 1ns/1ps
module adc_link_sva
  import adc_readout_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic clk_src_sel,
  input wire logic busy_n,
  input wire logic serial_data_out,
  input wire logic [7:0] parallel_data_bus,
  input wire logic pbus_oe,
  input wire logic sclk_dev_oe,
  input wire logic sclk_host_o,
  input wire logic serial_clock_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  int low_cnt; // Cycles busy has been low
  int pulse_cnt; // Converter clock pulses in this conversion
  logic pin_q; // Clock pin one cycle back
  // Both counts restart while busy is high, so a rise sees the whole run
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_cnt <= 0;
      pulse_cnt <= 0;
      pin_q <= 1'h0;
    end
    else
    begin
      low_cnt <= busy_n ? 0 : low_cnt + 1;
      pulse_cnt <= busy_n ? 0 : pulse_cnt + int'(sclk_dev_oe && serial_clock_pin && !pin_q);
      pin_q <= serial_clock_pin;
    end
  end
  // Host clock high phase: four cycles, then low
  sequence host_high_s;
    sclk_host_o [*4] ##1 !sclk_host_o;
  endsequence
  AST_BUS_DRIVE:
    assert property ($rose(pbus_oe) |-> !cs_n && read_convert)
    else $error("bus enabled without select and read");
  AST_LOW_NIBBLE:
    assert property ((pbus_oe && byte_select) [*5] |-> parallel_data_bus[3:0] == 4'h0)
    else $error("low nibble lines not zero");
  AST_BUSY_LEN:
    assert property ($rose(busy_n) |-> low_cnt == CONV_CYC)
    else $error("busy low run has wrong length");
  AST_PULSE_CNT:
    assert property ($rose(busy_n) && !clk_src_sel |-> pulse_cnt == 12)
    else $error("internal clock pulse count wrong");
  AST_BIT_STABLE:
    assert property (sclk_dev_oe && (serial_clock_pin || pin_q) |-> $stable(serial_data_out))
    else $error("serial bit moved around a clock edge");
  AST_HOST_GATE:
    assert property (sclk_host_o && clk_src_sel |-> !cs_n && read_convert)
    else $error("host clock pulsed outside a read");
  AST_HOST_DUTY:
    assert property ($rose(sclk_host_o) |-> host_high_s)
    else $error("host clock high time wrong");
  AST_RELEASE:
    assert property ($rose(busy_n) |-> cs_n || read_convert)
    else $error("convert still asserted at busy rise");
endmodule : adc_link_sva

// File: sim/adc_result_readout_port_tb.sv
// Bench joining the converter and host ends through the link
`timescale 1ns/1ps
module adc_result_readout_port_tb;
  import adc_readout_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hf; // Only the low lane matters
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [RES_W-1:0] analog_code = '0; // Sample caught at convert
  logic chain_in = 1'h0; // Daisy-chain level
  logic sample_strobe, result_valid;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Full scale, midscale, one step below, negative full scale
  logic [RES_W-1:0] twos_tab [4] = '{12'h7ff, 12'h000, 12'hfff, 12'h800};
  logic [RES_W-1:0] sb_tab [4] = '{12'hfff, 12'h800, 12'h7ff, 12'h000};
  always #10 clk = ~clk;
  adc_link_if link ();
  adc_readout_device i_adc_readout_device (.*);
  adc_readout_host i_adc_readout_host (.*);
  adc_link_sva i_adc_link_sva (.clk(clk), .rst(rst), .cs_n(link.cs_n),
    .read_convert(link.read_convert), .byte_select(link.byte_select),
    .clk_src_sel(link.clk_src_sel), .busy_n(link.busy_n),
    .serial_data_out(link.serial_data_out), .parallel_data_bus(link.parallel_data_bus),
    .pbus_oe(link.pbus_oe), .sclk_dev_oe(link.sclk_dev_oe), .sclk_host_o(link.sclk_host_o),
    .serial_clock_pin(link.serial_clock_pin));
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // A wait that ran out counts as a mismatch
  task automatic time_out();
    n_mismatch++;
    print_verdict();
  endtask : time_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One AXI4-Lite transfer, then one idle edge
  task automatic axi(input logic wr, input logic [AXI_AW-1:0] a, input logic [31:0] d);
    logic aw, w, ar, done;
    done = 1'h0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      s_axi_awvalid <= s_axi_awvalid && !aw;
      s_axi_wvalid <= s_axi_wvalid && !w;
      s_axi_arvalid <= s_axi_arvalid && !ar;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    @(posedge clk);
    if (!done)
      time_out();
  endtask : axi
  // Issue an engine command, then poll until it and any conversion finish
  task automatic cmd(input logic [1:0] c);
    int i;
    axi(1'h1, OFF_STATUS, 32'h1 << ST_DONE_BIT);
    axi(1'h1, OFF_CMD, {30'h0, c});
    for (i = 0; i < 400; i++)
    begin
      axi(1'h0, OFF_STATUS, 32'h0);
      if (q[ST_DONE_BIT] && q[ST_BUSY_N_BIT] && !q[ST_ENGINE_BIT])
        break;
    end
    if (i == 400)
      time_out();
  endtask : cmd
  // External clock: convert, read on the bus first, then serially
  task automatic t_format(input logic fmt, input logic [RES_W-1:0] v, input logic [RES_W-1:0] e);
    axi(1'h1, OFF_CTRL, {30'h0, fmt, 1'h1});
    analog_code <= v;
    cmd(CMD_CONVERT);
    cmd(CMD_PAR_READ);
    axi(1'h0, OFF_PAR, 32'h0);
    check("parallel code", q, {20'h0, e});
    cmd(CMD_SER_READ);
    axi(1'h0, OFF_SER, 32'h0);
    check("serial code", q, {20'h0, e});
    check("valid flag", {31'h0, result_valid}, 32'h1);
  endtask : t_format
  // Internal clock: a conversion streams out the result before it
  task automatic t_internal();
    axi(1'h1, OFF_CTRL, 32'h0);
    chain_in <= 1'h1;
    analog_code <= 12'h3c5;
    cmd(CMD_CONVERT);
    analog_code <= 12'h2a6;
    cmd(CMD_CONVERT);
    axi(1'h0, OFF_SER, 32'h0);
    check("internal serial", q, 32'h3c5);
    cmd(CMD_PAR_READ);
    axi(1'h0, OFF_PAR, 32'h0);
    check("reloaded result", q, 32'h2a6);
  endtask : t_internal
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // The first conversion after reset never reaches the output register
    analog_code <= 12'h5a3;
    cmd(CMD_CONVERT);
    cmd(CMD_PAR_READ);
    axi(1'h0, OFF_PAR, 32'h0);
    check("first result", q, 32'h0);
    check("first valid", {31'h0, result_valid}, 32'h0);
    for (int k = 0; k < 8; k++)
      t_format(k[2], twos_tab[k[1:0]], k[2] ? sb_tab[k[1:0]] : twos_tab[k[1:0]]);
    t_internal();
    // Unmapped offsets are refused
    axi(1'h1, 5'h1c, 32'h3);
    check("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi(1'h0, 5'h14, 32'h0);
    check("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
    print_verdict();
  end
endmodule : adc_result_readout_port_tb
